// >>> logic/amc_pkg.sv
`default_nettype none
package amc_pkg;
	// ----------------------------------------------------------------
	// Register geometry
	// ----------------------------------------------------------------
	localparam int unsigned MODE_W       = 16;
	localparam logic [15:0] MODE_RESET   = 16'h0174;
	localparam int unsigned MODE_MSB     = 15;
	localparam int unsigned MODE_LSB     = 13;
	localparam int unsigned UNIPOLAR_BIT = 12;
	localparam int unsigned PORT_EN_BIT  = 11;
	localparam int unsigned PORT_HI_BIT  = 10;
	localparam int unsigned PORT_LO_BIT  = 9;
	localparam int unsigned RANGE_MSB    = 6;
	localparam int unsigned RANGE_LSB    = 4;
	localparam int unsigned CHAN_MSB     = 2;
	localparam int unsigned CHAN_LSB     = 0;
	localparam int unsigned RANGE_W      = 3;
	localparam int unsigned CHAN_W       = 3;

	// Mode code bits: top bit marks a calibration, low bit full scale
	localparam int unsigned CAL_FLAG  = 2;
	localparam int unsigned GAIN_FLAG = 0;

	// ----------------------------------------------------------------
	// Data path and calibration store
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W          = 24;
	localparam int unsigned CAL_SAMPLES_DEF = 16;
	localparam logic [23:0] OFFSET_RESET    = 24'h000000;
	localparam logic [23:0] GAIN_RESET      = 24'h000000;

	typedef enum logic [2:0] {
		MODE_SYNC    = 3'b000,
		MODE_CONT    = 3'b001,
		MODE_SINGLE  = 3'b010,
		MODE_STANDBY = 3'b011,
		MODE_ZS_SELF = 3'b100,
		MODE_FS_SELF = 3'b101,
		MODE_ZS_SYS  = 3'b110,
		MODE_FS_SYS  = 3'b111
	} amc_mode_e;

	typedef enum logic [0:0] {
		CAL_IDLE = 1'b0,
		CAL_RUN  = 1'b1
	} amc_cal_state_e;
endpackage: amc_pkg
`default_nettype wire

// >>> logic/amc_cal_if.sv
`default_nettype none
interface amc_cal_if #(
	parameter int unsigned DW = 24
);
	logic          start;
	logic          abort;
	logic          busy;
	logic          done;
	logic [DW-1:0] result;

	// Mode control side and sequencer side
	modport ctrl (output start, output abort,
		input busy, input done, input result);
	modport seq (input start, input abort,
		output busy, output done, output result);
endinterface: amc_cal_if
`default_nettype wire

// >>> logic/amc_cal_seq.sv
`default_nettype none
module amc_cal_seq
	import amc_pkg::*;
#(
	parameter int unsigned DW      = DATA_W,
	parameter int unsigned SAMPLES = CAL_SAMPLES_DEF
)(
	input  wire logic          clock,
	input  wire logic          arst_n,
	input  wire logic          sampleValid,
	input  wire logic [DW-1:0] sampleData,
	amc_cal_if.seq             cal
);
	// Averaging by shift, so SAMPLES must be a power of two, at least 2
	localparam int unsigned   SH   = $clog2(SAMPLES);
	localparam int unsigned   AW   = DW + SH;
	localparam logic [SH-1:0] LAST = SH'(SAMPLES - 1);

	amc_cal_state_e stateReg;
	amc_cal_state_e stateNext;
	logic [SH-1:0]  cntReg;
	logic [SH-1:0]  cntNext;
	logic [AW-1:0]  accReg;
	logic [AW-1:0]  accNext;
	logic [AW-1:0]  sum;
	logic           doneNow;

	// ----------------------------------------------------------------
	// Sample accumulation
	// ----------------------------------------------------------------
	// A start restarts from scratch; an abort drops the partial sum
	always_comb begin
		stateNext = stateReg;
		cntNext   = cntReg;
		accNext   = accReg;
		doneNow   = 1'b0;
		sum       = accReg + {{SH{sampleData[DW-1]}}, sampleData};
		if (cal.start) begin
			stateNext = CAL_RUN;
			cntNext   = '0;
			accNext   = '0;
		end else if (cal.abort) begin
			stateNext = CAL_IDLE; // [RULE15]
		end else begin
			unique case (stateReg)
				CAL_IDLE: begin
				end
				CAL_RUN: begin
					if (sampleValid) begin
						accNext = sum;
						if (cntReg == LAST) begin
							doneNow   = 1'b1;
							stateNext = CAL_IDLE;
						end else begin
							cntNext = cntReg + 1'b1;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			stateReg <= CAL_IDLE;
			cntReg   <= '0;
			accReg   <= '0;
		end else begin
			stateReg <= stateNext;
			cntReg   <= cntNext;
			accReg   <= accNext;
		end
	end

	assign cal.busy   = (stateReg == CAL_RUN);
	assign cal.done   = doneNow;
	assign cal.result = sum[SH +: DW]; // Mean of the window

	// An abandoned run goes idle at once and never reports
	chk_abort_goes_idle: assert property (@(posedge clock) // [RULE15]
		disable iff (!arst_n)
		(cal.abort && !cal.start) |-> !cal.done ##1 !cal.busy)
		else $error("aborted calibration still running");
endmodule: amc_cal_seq
`default_nettype wire

// >>> logic/amc_out_coder.sv
`default_nettype none
module amc_out_coder
	import amc_pkg::*;
#(
	parameter int unsigned DW = DATA_W
)(
	input  wire logic          clock,
	input  wire logic          arst_n,
	input  wire logic          unipolar,
	input  wire logic          rawValid,
	input  wire logic [DW-1:0] rawData,
	output logic               codeValid,
	output logic [DW-1:0]      codeData
);
	localparam logic [DW-1:0] MSB_MASK = {1'b1, {(DW-1){1'b0}}};
	localparam logic [DW-1:0] POS_FULL = {1'b0, {(DW-1){1'b1}}};

	logic          validNext;
	logic [DW-1:0] dataNext;
	logic [DW-1:0] flipped;

	// ----------------------------------------------------------------
	// Output coding
	// ----------------------------------------------------------------
	// Bipolar is offset binary; unipolar clips below zero and doubles
	always_comb begin
		flipped   = rawData ^ MSB_MASK;
		validNext = rawValid;
		dataNext  = codeData;
		if (rawValid) begin
			if (!unipolar) begin
				dataNext = flipped; // [RULE9]
			end else if (rawData[DW-1]) begin
				dataNext = '0; // [RULE10]
			end else begin
				dataNext = {rawData[DW-2:0], rawData[DW-2]}; // [RULE10]
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			codeValid <= 1'b0;
			codeData  <= '0;
		end else begin
			codeValid <= validNext;
			codeData  <= dataNext;
		end
	end

	chk_bipolar_code: assert property (@(posedge clock) // [RULE9]
		disable iff (!arst_n)
		(rawValid && !unipolar) |=> codeData == $past(flipped))
		else $error("bipolar code is not offset binary");

	chk_unipolar_ends: assert property (@(posedge clock) // [RULE10]
		disable iff (!arst_n)
		(rawValid && unipolar && rawData == POS_FULL) |=> &codeData)
		else $error("unipolar full scale not all ones");

	chk_unipolar_zero: assert property (@(posedge clock) // [RULE10]
		disable iff (!arst_n)
		(rawValid && unipolar && (rawData[DW-1] || rawData == '0))
		|=> codeData == '0)
		else $error("unipolar zero or below not all zeros");
endmodule: amc_out_coder
`default_nettype wire

// >>> logic/amc_mode_cal_ctrl.sv
// What this block does
// (RULE1) Standby mode code equals asserting standby pin
// (RULE2) Standby pin leaves stored mode field alone
// (RULE3) Zero self calibration writes offset, returns sync
// (RULE4) Full self calibration writes gain, returns sync
// (RULE5) Zero system calibration writes offset, returns sync
// (RULE6) Full system calibration writes gain, returns sync
// (RULE7) Ready pin and bit high while calibrating
// (RULE8) Host keeps input steady during system calibration
// (RULE9) Polarity bit zero gives offset binary codes
// (RULE10) Polarity bit one gives straight unipolar codes
// (RULE11) Port enable turns shared pins into outputs
// (RULE12) Mode write abandons current mode, starts new
// (RULE13) Sync mode or sync pin holds modulator
// (RULE14) Enabled port pins follow their stored bits
// (RULE15) Stores change only on completed calibration
`default_nettype none
module amc_mode_cal_ctrl
	import amc_pkg::*;
#(
	parameter int unsigned CAL_SAMPLES = CAL_SAMPLES_DEF
)(
	input  wire logic               clock,
	input  wire logic               arst_n,
	input  wire logic               regWrite,
	input  wire logic [MODE_W-1:0]  regWriteData,
	output logic      [MODE_W-1:0]  regReadData,
	input  wire logic               standbyPin_n,
	input  wire logic               syncPin_n,
	input  wire logic               sampleValid,
	input  wire logic [DATA_W-1:0]  sampleData,
	output logic                    ready_n,
	output logic                    readyStatusBit,
	output logic                    standbyActive,
	output logic                    modulatorHold,
	output logic                    inputShorted,
	output logic                    fullScaleRef,
	output logic      [CHAN_W-1:0]  channelSelect,
	output logic      [RANGE_W-1:0] rangeSelect,
	output logic      [DATA_W-1:0]  offsetCal,
	output logic      [DATA_W-1:0]  gainCal,
	output logic                    resultValid,
	output logic      [DATA_W-1:0]  resultCode,
	output logic                    sharedInput3PortHiOut,
	output logic                    sharedInput3PortHiOe,
	output logic                    sharedInput4PortLoOut,
	output logic                    sharedInput4PortLoOe
);
	// ----------------------------------------------------------------
	// State and decoded fields
	// ----------------------------------------------------------------
	logic [MODE_W-1:0] modeReg;
	logic [MODE_W-1:0] modeNext;
	logic [DATA_W-1:0] offsetReg;
	logic [DATA_W-1:0] offsetNext;
	logic [DATA_W-1:0] gainReg;
	logic [DATA_W-1:0] gainNext;
	amc_mode_e         modeField;
	amc_mode_e         writeMode;
	logic              calGain;
	logic              portEnable;
	logic              portBitHigh;
	logic              portBitLow;
	logic              unipolarSel;
	logic              filterValid;

	amc_cal_if #(.DW(DATA_W)) cal ();

	// Field views of the live register and of the incoming word
	assign modeField   = amc_mode_e'(modeReg[MODE_MSB:MODE_LSB]);
	assign writeMode   = amc_mode_e'(regWriteData[MODE_MSB:MODE_LSB]);
	assign calGain     = modeReg[MODE_LSB + GAIN_FLAG];
	assign portEnable  = modeReg[PORT_EN_BIT];
	assign portBitHigh = modeReg[PORT_HI_BIT];
	assign portBitLow  = modeReg[PORT_LO_BIT];
	assign unipolarSel = modeReg[UNIPOLAR_BIT];

	// ----------------------------------------------------------------
	// Calibration sequencer
	// ----------------------------------------------------------------
	// Any mode write cuts a running calibration short; a write that
	// names a calibration restarts the sequencer in the same edge
	assign cal.abort = regWrite; // [RULE12] [RULE15]
	assign cal.start = regWrite && writeMode[CAL_FLAG]; // [RULE12]

	amc_cal_seq #(
		.DW      (DATA_W),
		.SAMPLES (CAL_SAMPLES)
	) u_cal_seq (
		.clock       (clock),
		.arst_n      (arst_n),
		.sampleValid (sampleValid),
		.sampleData  (sampleData),
		.cal         (cal)
	);

	// Ready goes high with the start and low once back in sync
	assign ready_n        = cal.busy; // [RULE7]
	assign readyStatusBit = cal.busy; // [RULE7]

	// Self calibrations steer the front end internally; system ones
	// measure whatever the host applies, so its input must be steady
	assign inputShorted = cal.busy && modeField == MODE_ZS_SELF; // [RULE3]
	assign fullScaleRef = cal.busy && modeField == MODE_FS_SELF; // [RULE4]

	// Channel and gain reach the front end during calibration too
	assign channelSelect = modeReg[CHAN_MSB:CHAN_LSB]; // [RULE3]
	assign rangeSelect   = modeReg[RANGE_MSB:RANGE_LSB]; // [RULE3]

	// ----------------------------------------------------------------
	// Standby and sync
	// ----------------------------------------------------------------
	// Pins act alongside the field and never write it back
	assign standbyActive = modeField == MODE_STANDBY // [RULE1]
		|| !standbyPin_n; // [RULE2]
	assign modulatorHold = modeField == MODE_SYNC // [RULE13]
		|| !syncPin_n || standbyActive; // [RULE13]

	// ----------------------------------------------------------------
	// Mode register and calibration stores
	// ----------------------------------------------------------------
	// A host write wins over a finishing calibration; the sequencer
	// suppresses done whenever a write lands, so nothing is lost
	always_comb begin
		modeNext   = modeReg;
		offsetNext = offsetReg;
		gainNext   = gainReg;
		if (regWrite) begin
			modeNext = regWriteData; // [RULE12]
		end else if (cal.done) begin
			modeNext[MODE_MSB:MODE_LSB] = MODE_SYNC; // [RULE3] [RULE4]
			if (calGain) begin
				gainNext = cal.result; // [RULE4] [RULE6] [RULE15]
			end else begin
				offsetNext = cal.result; // [RULE3] [RULE5] [RULE15]
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			modeReg   <= MODE_RESET;
			offsetReg <= OFFSET_RESET;
			gainReg   <= GAIN_RESET;
		end else begin
			modeReg   <= modeNext;
			offsetReg <= offsetNext;
			gainReg   <= gainNext;
		end
	end

	assign regReadData = modeReg;
	assign offsetCal   = offsetReg;
	assign gainCal     = gainReg;

	// ----------------------------------------------------------------
	// Port pins
	// ----------------------------------------------------------------
	// Drivers off unless enabled, so the analog inputs stay usable
	assign sharedInput3PortHiOe  = portEnable; // [RULE11]
	assign sharedInput4PortLoOe  = portEnable; // [RULE11]
	assign sharedInput3PortHiOut = portEnable && portBitHigh; // [RULE14]
	assign sharedInput4PortLoOut = portEnable && portBitLow; // [RULE14]

	// ----------------------------------------------------------------
	// Result coding
	// ----------------------------------------------------------------
	// Only true conversions are coded; calibration samples stay inside
	assign filterValid = sampleValid && !modulatorHold && !cal.busy;

	amc_out_coder #(
		.DW (DATA_W)
	) u_out_coder (
		.clock     (clock),
		.arst_n    (arst_n),
		.unipolar  (unipolarSel),
		.rawValid  (filterValid),
		.rawData   (sampleData),
		.codeValid (resultValid),
		.codeData  (resultCode)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_standby_entry: assert property (@(posedge clock) // [RULE1]
		disable iff (!arst_n)
		(modeField == MODE_STANDBY || !standbyPin_n)
		|-> standbyActive && modulatorHold)
		else $error("standby not entered");

	chk_standby_keeps: assert property (@(posedge clock) // [RULE2]
		disable iff (!arst_n)
		(!standbyPin_n && !regWrite && !cal.done) |=> $stable(modeReg))
		else $error("standby pin altered mode field");

	chk_offset_update: assert property (@(posedge clock) // [RULE3]
		disable iff (!arst_n)
		(cal.done && !calGain)
		|=> offsetCal == $past(cal.result) && $stable(gainCal)
			&& modeField == MODE_SYNC)
		else $error("zero scale calibration did not update offset");

	chk_gain_update: assert property (@(posedge clock) // [RULE4]
		disable iff (!arst_n)
		(cal.done && calGain)
		|=> gainCal == $past(cal.result) && $stable(offsetCal)
			&& modeField == MODE_SYNC)
		else $error("full scale calibration did not update gain");

	chk_system_offset: assert property (@(posedge clock) // [RULE5]
		disable iff (!arst_n)
		(cal.done && modeField == MODE_ZS_SYS)
		|=> offsetCal == $past(cal.result) && !ready_n
			&& regReadData[MODE_MSB:MODE_LSB] == MODE_SYNC)
		else $error("system zero calibration did not update offset");

	chk_system_gain: assert property (@(posedge clock) // [RULE6]
		disable iff (!arst_n)
		(cal.done && modeField == MODE_FS_SYS)
		|=> gainCal == $past(cal.result) && !ready_n
			&& regReadData[MODE_MSB:MODE_LSB] == MODE_SYNC)
		else $error("system full calibration did not update gain");

	chk_ready_rises: assert property (@(posedge clock) // [RULE7]
		disable iff (!arst_n)
		(regWrite && writeMode[CAL_FLAG]) |=> ready_n && readyStatusBit)
		else $error("ready did not rise at calibration start");

	chk_ready_falls: assert property (@(posedge clock) // [RULE7]
		disable iff (!arst_n)
		cal.done |=> !ready_n && !readyStatusBit && modulatorHold)
		else $error("ready did not fall at calibration end");

	chk_mode_write: assert property (@(posedge clock) // [RULE12]
		disable iff (!arst_n)
		regWrite |=> regReadData == $past(regWriteData))
		else $error("mode write not taken immediately");

	chk_write_aborts: assert property (@(posedge clock) // [RULE12]
		disable iff (!arst_n)
		(regWrite && !writeMode[CAL_FLAG]) |=> !ready_n)
		else $error("mode write did not end calibration");

	chk_sync_hold: assert property (@(posedge clock) // [RULE13]
		disable iff (!arst_n)
		(modeField == MODE_SYNC || !syncPin_n)
		|-> modulatorHold ##1 !resultValid)
		else $error("sync did not hold the modulator");

	chk_port_drive: assert property (@(posedge clock) // [RULE11]
		disable iff (!arst_n)
		portEnable |-> sharedInput3PortHiOe && sharedInput4PortLoOe
			&& sharedInput3PortHiOut == modeReg[PORT_HI_BIT]
			&& sharedInput4PortLoOut == modeReg[PORT_LO_BIT])
		else $error("port pins not driven from port bits"); // [RULE14]

	chk_port_release: assert property (@(posedge clock) // [RULE11]
		disable iff (!arst_n)
		!portEnable |-> !sharedInput3PortHiOe && !sharedInput4PortLoOe)
		else $error("port drivers on while disabled");

	chk_store_guard: assert property (@(posedge clock) // [RULE15]
		disable iff (!arst_n)
		!cal.done |=> $stable(offsetCal) && $stable(gainCal))
		else $error("calibration store changed without completion");

	// Front end steering follows the requested calibration kind
	chk_short_input: assert property (@(posedge clock) // [RULE3]
		disable iff (!arst_n)
		(regWrite && writeMode == MODE_ZS_SELF)
		|=> inputShorted && !fullScaleRef)
		else $error("zero self calibration did not short the input");

	chk_full_ref: assert property (@(posedge clock) // [RULE4]
		disable iff (!arst_n)
		(regWrite && writeMode == MODE_FS_SELF)
		|=> fullScaleRef && !inputShorted)
		else $error("full self calibration did not select the reference");

	chk_front_idle: assert property (@(posedge clock) // [RULE3]
		disable iff (!arst_n)
		!ready_n |-> !inputShorted && !fullScaleRef)
		else $error("front end steered while not calibrating");

	chk_fields_follow: assert property (@(posedge clock) // [RULE3]
		disable iff (!arst_n)
		regWrite |=> channelSelect == $past(regWriteData[CHAN_MSB:CHAN_LSB])
			&& rangeSelect == $past(regWriteData[RANGE_MSB:RANGE_LSB]))
		else $error("channel or gain not taken from the mode write");

	// Ready must not drop early, or the host reads a stale store
	chk_ready_holds: assert property (@(posedge clock) // [RULE7]
		disable iff (!arst_n)
		(ready_n && !regWrite && !cal.done) |=> ready_n && readyStatusBit)
		else $error("ready fell before calibration completed");

	chk_sync_keeps: assert property (@(posedge clock) // [RULE13]
		disable iff (!arst_n)
		(!syncPin_n && !regWrite && !cal.done) |=> $stable(modeReg))
		else $error("sync pin altered mode field");

	chk_port_hold: assert property (@(posedge clock) // [RULE14]
		disable iff (!arst_n)
		(portEnable && !regWrite) |=> $stable(sharedInput3PortHiOut)
			&& $stable(sharedInput4PortLoOut))
		else $error("port pin level changed without a write");
endmodule: amc_mode_cal_ctrl
`default_nettype wire

// >>> test/amc_sample_src.sv
`default_nettype none
module amc_sample_src
	import amc_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              arst_n,
	input  wire logic              enable,
	input  wire logic [7:0]        gap,
	input  wire logic [DATA_W-1:0] level,
	output logic                   sampleValid,
	output logic [DATA_W-1:0]      sampleData
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] gapCnt;

	// ----------------------------------------------------------------
	// Filter output stand-in
	// ----------------------------------------------------------------
	// One sample every gap+1 cycles; a large gap gives a slow source
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			gapCnt      <= 8'h00;
			sampleValid <= 1'b0;
			sampleData  <= '1;
		end else begin
			sampleValid <= enable && gapCnt == gap;
			gapCnt      <= (gapCnt >= gap || !enable) ? 8'h00 : gapCnt + 8'h01;
			// Between pulses the word is junk, so it toggles every cycle
			if (enable && gapCnt == gap) begin
				sampleData <= level; // Level held by caller
			end else begin
				sampleData <= ~sampleData;
			end
		end
	end
endmodule: amc_sample_src
`default_nettype wire

// >>> test/tb.sv
`default_nettype none
`define CHK(a, e) begin nChecks++; if ((a) !== (e)) begin mismatches++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module tb import amc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	logic              clock;
	logic              arst_n;
	logic              regWrite;
	logic [15:0]       regWriteData;
	logic [15:0]       regReadData;
	logic              standbyPin_n;
	logic              syncPin_n;
	logic              sampleValid;
	logic [DATA_W-1:0] sampleData;
	logic              ready_n;
	logic              readyStatusBit;
	logic              standbyActive;
	logic              modulatorHold;
	logic              inputShorted;
	logic              fullScaleRef;
	logic [2:0]        channelSelect;
	logic [2:0]        rangeSelect;
	logic [DATA_W-1:0] offsetCal;
	logic [DATA_W-1:0] gainCal;
	logic              resultValid;
	logic [DATA_W-1:0] resultCode;
	logic              hiOut;
	logic              hiOe;
	logic              loOut;
	logic              loOe;
	logic              srcEn;
	logic [7:0]        srcGap;
	logic [DATA_W-1:0] srcLevel;
	logic [DATA_W-1:0] offExp;
	logic [DATA_W-1:0] gainExp;
	logic [DATA_W-1:0] codeIn [5];
	logic [DATA_W-1:0] codeExp [5];
	int                mismatches;
	int                nChecks;
	int                cyc;
	int                hits;

	amc_mode_cal_ctrl #(.CAL_SAMPLES(2)) DUT (
		.clock(clock), .arst_n(arst_n), .regWrite(regWrite),
		.regWriteData(regWriteData), .regReadData(regReadData),
		.standbyPin_n(standbyPin_n), .syncPin_n(syncPin_n),
		.sampleValid(sampleValid), .sampleData(sampleData),
		.ready_n(ready_n), .readyStatusBit(readyStatusBit),
		.standbyActive(standbyActive), .modulatorHold(modulatorHold),
		.inputShorted(inputShorted), .fullScaleRef(fullScaleRef),
		.channelSelect(channelSelect), .rangeSelect(rangeSelect),
		.offsetCal(offsetCal), .gainCal(gainCal),
		.resultValid(resultValid), .resultCode(resultCode),
		.sharedInput3PortHiOut(hiOut), .sharedInput3PortHiOe(hiOe),
		.sharedInput4PortLoOut(loOut), .sharedInput4PortLoOe(loOe)
	);

	amc_sample_src src (
		.clock(clock), .arst_n(arst_n), .enable(srcEn), .gap(srcGap),
		.level(srcLevel), .sampleValid(sampleValid),
		.sampleData(sampleData)
	);

	// ----------------------------------------------------------------
	// Clock, timeout and host-side tasks
	// ----------------------------------------------------------------
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// Whole run needs well under a thousand cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			results();
		end
	end

	task automatic results;
		$display("checks %0d mismatches %0d", nChecks, mismatches);
		if (mismatches == 0 && nChecks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask: results

	// One mode register write; settled values readable on return
	task automatic wr(input logic [15:0] w);
		@(posedge clock);
		regWrite     <= 1'b1;
		regWriteData <= w;
		@(posedge clock);
		regWrite <= 1'b0;
		#1;
	endtask: wr

	// Bounded wait for a level or a one-cycle pulse
	task automatic waitFor(input bit pulse);
		for (int i = 0; i < 100; i++) begin
			if (pulse ? resultValid === 1'b1 : ready_n === 1'b0) begin
				break;
			end
			@(posedge clock);
			#1;
		end
	endtask: waitFor

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		arst_n = 1'b0; regWrite = 1'b0; regWriteData = 16'h0000;
		standbyPin_n = 1'b1; syncPin_n = 1'b1;
		srcEn = 1'b0; srcGap = 8'h03; srcLevel = 24'h000000;
		offExp = 24'h000000; gainExp = 24'h000000;
		codeIn = '{24'h000000, 24'hfff000, 24'h123456, 24'hfff000, 24'h7fffff};
		codeExp = '{24'h800000, 24'h7ff000, 24'h2468ac, 24'h000000, 24'hffffff};
		repeat (6) @(posedge clock);
		arst_n <= 1'b1;
		#1;
		`CHK(regReadData, 16'h0174)
		`CHK({ready_n, channelSelect, rangeSelect}, 7'b0100111)
		`CHK(modulatorHold, 1'b1)
		`CHK({offsetCal, gainCal}, 48'h0)
		$display("test reset done");

		// Every calibration code, stores and ready indication
		for (int m = 4; m < 8; m++) begin
			@(posedge clock);
			srcLevel <= 24'h000100 + 24'(m); // Held steady
			srcEn    <= 1'b1;
			wr({m[2:0], 13'h0174});
			`CHK({ready_n, readyStatusBit}, 2'b11)
			`CHK(inputShorted, m == 4)
			`CHK(fullScaleRef, m == 5)
			if (m[0]) begin
				gainExp = 24'h000100 + 24'(m);
			end else begin
				offExp = 24'h000100 + 24'(m);
			end
			waitFor(1'b0);
			`CHK({ready_n, readyStatusBit}, 2'b00)
			`CHK(regReadData, 16'h0174)
			`CHK(offsetCal, offExp)
			`CHK(gainCal, gainExp)
		end
		$display("test calibration done");

		// Cut short after one sample, then by a plain mode write;
		// a nine-edge window at gap 8 can never hold a second sample
		@(posedge clock);
		srcGap <= 8'h08;
		srcLevel <= 24'h0abcde;
		wr(16'h8174);
		repeat (8) @(posedge clock);
		wr(16'hc174);
		`CHK(ready_n, 1'b1)
		wr(16'h2174);
		#1;
		`CHK({ready_n, modulatorHold}, 2'b00)
		`CHK({offsetCal, gainCal}, {offExp, gainExp})
		$display("test abort done");

		// Standby by code and by pin
		wr(16'h6174);
		`CHK({standbyActive, modulatorHold}, 2'b11)
		wr(16'h2174);
		@(posedge clock);
		standbyPin_n <= 1'b0;
		#1;
		`CHK({standbyActive, regReadData}, {1'b1, 16'h2174})
		@(posedge clock);
		standbyPin_n <= 1'b1;
		syncPin_n    <= 1'b0;
		srcGap       <= 8'h02;
		hits = 0;
		repeat (12) begin
			@(posedge clock);
			#1;
			hits += resultValid;
		end
		`CHK({modulatorHold, regReadData}, {1'b1, 16'h2174})
		`CHK(hits, 0)
		@(posedge clock);
		syncPin_n <= 1'b1;
		wr(16'h0174);
		`CHK(modulatorHold, 1'b1)
		$display("test standby and sync done");

		// Output coding in both polarities
		for (int k = 0; k < 5; k++) begin
			@(posedge clock);
			srcEn    <= 1'b0;
			srcLevel <= codeIn[k];
			wr({3'b001, k > 1, 12'h174});
			@(posedge clock);
			srcEn <= 1'b1;
			@(posedge clock);
			#1;
			waitFor(1'b1);
			`CHK(resultCode, codeExp[k])
		end
		$display("test coding done");

		// Port pins
		wr(16'h0d74);
		`CHK({hiOe, loOe, hiOut, loOut}, 4'b1110)
		wr(16'h0b74);
		`CHK({hiOe, loOe, hiOut, loOut}, 4'b1101)
		wr(16'h0674);
		`CHK({hiOe, loOe, hiOut, loOut}, 4'b0000)
		$display("test port done");
		results();
	end
endmodule: tb
`default_nettype wire
